// ---- ovtrip_core.sv ----
// Over-temperature shutdown core: latches a sensor trip, stops clocks, drives the trip pin.
// Assumes sensor_trip is synchronous to clk and supply_valid_in is an asynchronous pin.
//
// How it works
// R01: Sensor trip at the damage level (about 135 C) asserts the active-low trip output.
// R02: While the trip is set, the internal clock stop output is asserted.
// R03: Platform logic removes core supply after seeing the trip output asserted.
// R04: Reset-cleared stepping: latch holds until reset; nothing else clears it.
// R05: Reset-cleared stepping: reset clears the output; a persisting trip sets it again.
// R06: Supply stepping: pin drive enabled within 10 us of supply valid, off on fall.
// R07: Supply stepping: latch holds until supply valid falls, which clears it.
// R08: Supply stepping: persisting trip reasserts the output within 10 us of supply valid.
// R09: Trip input is synchronous; a parameter selects reset or supply clearing.
`timescale 1ns/1ps
module ovtrip_core #(
  parameter logic STEPPING = ovtrip_pkg::OVTRIP_STEP_SUPPLY_CLEARED,
  parameter int unsigned ENABLE_WAIT = ovtrip_pkg::OVTRIP_ENABLE_WAIT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sensor_trip,
  input wire logic supply_valid_in,
  output logic overtemp_shutdown_n,
  output logic overtemp_shutdown_oe,
  output logic core_clk_stop,
  output ovtrip_pkg::ovtrip_out_t status
);
  import ovtrip_pkg::*;

  typedef struct packed {
    ovtrip_drv_t drv;
    logic [OVTRIP_CNT_W-1:0] cnt;
    logic latch;
    logic out_n;
    logic oe;
    logic stop;
    logic pin_oe;
  } ovtrip_state_t;

  localparam logic [OVTRIP_CNT_W-1:0] WAIT_LAST = OVTRIP_CNT_W'(ENABLE_WAIT - 1);

  ovtrip_state_t st_q, st_d;
  logic supply_ok;
  logic is_supply_step;

  assign is_supply_step = (STEPPING == OVTRIP_STEP_SUPPLY_CLEARED);

  ovtrip_sync u_supply_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in(supply_valid_in),
    .level_out(supply_ok)
  );

  always_comb begin
    st_d = st_q;
    if (is_supply_step) begin
      unique case (st_q.drv)
        OVTRIP_OFF: begin
          st_d.cnt = '0;
          if (supply_ok) begin
            st_d.drv = OVTRIP_ARM;
          end
        end
        OVTRIP_ARM: begin
          st_d.cnt = st_q.cnt + 1'b1;
          if (!supply_ok) begin
            st_d.drv = OVTRIP_OFF;
          end else if (st_q.cnt == WAIT_LAST) begin
            st_d.drv = OVTRIP_DRV; // see R06
          end
        end
        OVTRIP_DRV: begin
          if (!supply_ok) begin
            st_d.drv = OVTRIP_OFF; // see R06
          end
        end
        default: begin
          st_d.drv = OVTRIP_OFF;
        end
      endcase
      // Supply fall clears the latch; otherwise it only sets.
      if (!supply_ok) begin
        st_d.latch = 1'b0; // see R07
      end else if (sensor_trip) begin
        st_d.latch = 1'b1; // see R01, R08, R09
      end
      st_d.oe = (st_d.drv == OVTRIP_DRV); // see R06
      st_d.out_n = !(st_d.latch && st_d.oe); // see R08
    end else begin
      // Reset is the only clear, handled in the clocked process.
      st_d.drv = OVTRIP_DRV;
      st_d.cnt = '0;
      if (sensor_trip) begin
        st_d.latch = 1'b1; // see R01, R04, R09
      end
      st_d.oe = 1'b1;
      st_d.out_n = !st_d.latch;
    end
    st_d.stop = st_d.latch; // see R02
    // The open-drain enable is registered so the pin never sees a combinational glitch.
    st_d.pin_oe = st_d.oe && !st_d.out_n; // see R01
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{drv: OVTRIP_OFF, cnt: '0, latch: OVTRIP_LATCH_RST,
                out_n: 1'b1, oe: 1'b0, stop: 1'b0, pin_oe: 1'b0}; // see R05
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // The pin is open drain: drive low only while tripped, so oe follows the trip.
  assign overtemp_shutdown_n = st_q.out_n;
  assign overtemp_shutdown_oe = st_q.pin_oe;
  assign core_clk_stop = st_q.stop;
  assign status = '{latch: st_q.latch, out_n: st_q.out_n, clk_stop: st_q.stop,
                    drive_en: st_q.oe};

  // The whole-cycle budget in the package must cover our own wait.
  localparam int unsigned BUDGET = OVTRIP_ENABLE_CYC;
  initial begin
    if (ENABLE_WAIT + 4 > BUDGET) begin
      $error("enable wait exceeds the 10 us ceiling");
    end
  end

  sequence s_trip_seen;
    clk_en && sensor_trip && (!is_supply_step || supply_ok);
  endsequence

  a_trip_sets_latch: assert property (@(posedge clk) disable iff (sys_rst) // see R01
    s_trip_seen |=> st_q.latch || !clk_en)
    else $error("sensor trip did not set the latch");

  a_clock_stop_follows: assert property (@(posedge clk) disable iff (sys_rst) // see R02
    core_clk_stop == st_q.latch)
    else $error("clock stop differs from trip latch");

  a_reset_latch_holds: assert property (@(posedge clk) disable iff (sys_rst) // see R04
    (!is_supply_step && st_q.latch) |=> st_q.latch)
    else $error("latch cleared without reset");

  a_reset_clears_out: assert property (@(posedge clk) // see R05
    sys_rst |=> overtemp_shutdown_n && !core_clk_stop)
    else $error("reset did not clear the trip output");

  a_drive_on_supply: assert property (@(posedge clk) disable iff (sys_rst) // see R06
    (is_supply_step && clk_en && $rose(supply_ok)) ##1 (clk_en && supply_ok)[*8]
    |-> ##[0:20] st_q.oe)
    else $error("drive not enabled after supply valid");

  a_drive_off_supply: assert property (@(posedge clk) disable iff (sys_rst) // see R06
    (is_supply_step && clk_en && !supply_ok) |=> !st_q.oe && overtemp_shutdown_n)
    else $error("drive left on after supply valid fell");

  a_supply_latch_holds: assert property (@(posedge clk) disable iff (sys_rst) // see R07
    (is_supply_step && st_q.latch && supply_ok) |=> st_q.latch)
    else $error("latch cleared while supply valid");

  a_retrip_after_supply: assert property (@(posedge clk) disable iff (sys_rst) // see R08
    (is_supply_step && st_q.oe && st_q.latch) |=> !overtemp_shutdown_n || !clk_en
      || !supply_ok)
    else $error("trip output not asserted while driving");

endmodule

// ---- ovtrip_pkg.sv ----
// Package for the over-temperature shutdown block: timing counts, stepping choice and state.
// Assumes a single 100 MHz clock domain shared by every user of the package.
package ovtrip_pkg;

  // Clock period in ns and the longest enable delay after supply valid, in us.
  localparam int unsigned OVTRIP_CLK_PERIOD_NS = 10;
  localparam int unsigned OVTRIP_ENABLE_MAX_US = 10;
  // A longest time rounds down to whole cycles, never below one.
  localparam int unsigned OVTRIP_ENABLE_CYC_RAW = (OVTRIP_ENABLE_MAX_US * 1000) / OVTRIP_CLK_PERIOD_NS;
  localparam int unsigned OVTRIP_ENABLE_CYC = (OVTRIP_ENABLE_CYC_RAW < 1) ? 1 : OVTRIP_ENABLE_CYC_RAW;
  // Our enable wait in cycles; well inside the ceiling.
  localparam int unsigned OVTRIP_ENABLE_WAIT = 16;
  localparam int unsigned OVTRIP_CNT_W = 14;

  // Trip level of the sensor in degrees Celsius, for reference by the sensor model.
  localparam int unsigned OVTRIP_TRIP_DEG_C = 135;

  // Stepping select values.
  localparam logic OVTRIP_STEP_RESET_CLEARED = 1'b0;
  localparam logic OVTRIP_STEP_SUPPLY_CLEARED = 1'b1;

  localparam logic OVTRIP_LATCH_RST = 1'b0;

  // Drive enable states, Gray coded along off, arming, driving.
  typedef enum logic [1:0] {
    OVTRIP_OFF = 2'b00,
    OVTRIP_ARM = 2'b01,
    OVTRIP_DRV = 2'b11
  } ovtrip_drv_t;

  typedef struct packed {
    logic latch;
    logic out_n;
    logic clk_stop;
    logic drive_en;
  } ovtrip_out_t;

endpackage

// ---- ovtrip_sync.sv ----
// Three-stage synchroniser for a pin level, with agreement of the last two stages.
// Assumes the input is asynchronous to clk; the first stage is read only by the second.
`timescale 1ns/1ps
module ovtrip_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ovtrip_sync_t;

  ovtrip_sync_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A change counts only when the second and third stages agree.
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule

// ---- ovtrip_plat.sv ----
// Platform power control model facing the over-temperature shutdown pin.
// Assumes an open-drain trip pin with a pull-up, sampled on the device clock.
`timescale 1ns/1ps
module ovtrip_plat (
  input wire logic clk,
  input wire logic power_req,
  input wire logic trip_pin_n,
  output logic supply_valid
);
  logic cut_q = 1'b0;
  // A seen trip cuts supply until power is requested anew, so it cannot bounce back on.
  always_ff @(posedge clk) begin
    cut_q <= power_req & (cut_q | ~trip_pin_n);
  end
  assign supply_valid = power_req & ~cut_q;
endmodule

// ---- thermal_trip_shutdown_tb.sv ----
// Testbench for the shutdown core, one instance of each stepping.
// Assumes the platform model on the supply-cleared instance and a pull-up on its pin.
`timescale 1ns/1ps
module thermal_trip_shutdown_tb;
  import ovtrip_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trip_a = 1'b0;
  logic trip_b = 1'b0;
  logic power_req = 1'b0;
  logic en_b = 1'b1;
  logic supply_valid, n_a, oe_a, stop_a, n_b, oe_b, stop_b;
  ovtrip_out_t st_a, st_b;
  wire pin_a = oe_a ? 1'b0 : 1'b1;
  int err_total = 0;
  int checks = 0;
  int i;
  initial forever #5 clk = ~clk;
  ovtrip_core #(.STEPPING(OVTRIP_STEP_SUPPLY_CLEARED), .ENABLE_WAIT(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .sensor_trip(trip_a),
    .supply_valid_in(supply_valid), .overtemp_shutdown_n(n_a),
    .overtemp_shutdown_oe(oe_a), .core_clk_stop(stop_a), .status(st_a));
  ovtrip_core #(.STEPPING(OVTRIP_STEP_RESET_CLEARED), .ENABLE_WAIT(4)) uut_b (
    .clk(clk), .sys_rst(sys_rst), .clk_en(en_b), .sensor_trip(trip_b),
    .supply_valid_in(1'b0), .overtemp_shutdown_n(n_b),
    .overtemp_shutdown_oe(oe_b), .core_clk_stop(stop_b), .status(st_b));
  ovtrip_plat plat (.clk(clk), .power_req(power_req), .trip_pin_n(pin_a),
    .supply_valid(supply_valid));
  task automatic chk(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset_step();
    @(posedge clk) trip_b <= 1'b1;
    @(posedge clk) trip_b <= 1'b0;
    #1;
    chk("b out_n", n_b, 1'b0);
    chk("b oe", oe_b, 1'b1);
    chk("b clk_stop", stop_b, 1'b1);
    chk("b status latch", st_b.latch, 1'b1);
    step(20);
    chk("b held", n_b, 1'b0);
    @(posedge clk) begin
      sys_rst <= 1'b1;
      trip_b <= 1'b1;
    end
    @(posedge clk) sys_rst <= 1'b0;
    #1;
    chk("b cleared", n_b, 1'b1);
    step(1);
    chk("b set again", n_b, 1'b0);
    @(posedge clk) trip_b <= 1'b0;
    $display("test reset_step done");
  endtask
  task automatic t_freeze();
    @(posedge clk) begin
      sys_rst <= 1'b1;
      en_b <= 1'b0;
    end
    @(posedge clk) begin
      sys_rst <= 1'b0;
      trip_b <= 1'b1;
    end
    @(posedge clk) trip_b <= 1'b0;
    #1;
    chk("b reset while frozen", n_b, 1'b1);
    chk("b frozen latch", st_b.latch, 1'b0);
    @(posedge clk) en_b <= 1'b1;
    step(2);
    chk("b no late trip", n_b, 1'b1);
    $display("test freeze done");
  endtask
  task automatic t_supply_step();
    @(posedge clk) trip_a <= 1'b1;
    step(3);
    chk("a ignored", n_a, 1'b1);
    @(posedge clk) begin
      trip_a <= 1'b0;
      power_req <= 1'b1;
    end
    for (i = 0; i < 1000 && st_a.drive_en !== 1'b1; i++) step(1);
    chk("a drive on", st_a.drive_en, 1'b1);
    if (st_a.drive_en !== 1'b1) give_verdict();
    @(posedge clk) trip_a <= 1'b1;
    @(posedge clk) trip_a <= 1'b0;
    #1;
    chk("a out_n", n_a, 1'b0);
    chk("a oe", oe_a, 1'b1);
    chk("a clk_stop", stop_a, 1'b1);
    chk("a status latch", st_a.latch, 1'b1);
    for (i = 0; i < 30 && n_a !== 1'b1; i++) step(1);
    chk("a supply cut", supply_valid, 1'b0);
    chk("a pin released", oe_a, 1'b0);
    chk("a cleared", n_a, 1'b1);
    chk("a drive off", st_a.drive_en, 1'b0);
    if (n_a !== 1'b1) give_verdict();
    $display("test supply_step done");
  endtask
  task automatic t_rearm();
    @(posedge clk) begin
      trip_a <= 1'b1;
      power_req <= 1'b0;
    end
    step(8);
    chk("a low supply", n_a, 1'b1);
    @(posedge clk) power_req <= 1'b1;
    for (i = 0; i < 1000 && n_a !== 1'b0; i++) step(1);
    chk("a rearm", n_a, 1'b0);
    if (n_a !== 1'b0) give_verdict();
    @(posedge clk) trip_a <= 1'b0;
    $display("test rearm done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_step();
    t_freeze();
    t_supply_step();
    t_rearm();
    give_verdict();
  end
endmodule
